// ---- src/pcgbc_pkg.sv ----
`default_nettype none
package pcgbc_pkg;
    // Register map, byte addresses on the APB side
    localparam int ADDR_W = 12;
    localparam logic [11:0] GATE_OFFSET = 12'h01c;
    localparam logic [11:0] BDCR_OFFSET = 12'h020;
    localparam logic [31:0] GATE_RESET = 32'h00000000;
    localparam logic [31:0] BDCR_RESET = 32'h00000018;

    // Low-speed bus clock gate bit positions
    localparam int CONVERTER_OUT_CLK_EN = 29;
    localparam int POWER_CTL_CLK_EN = 28;
    localparam int BACKUP_IF_CLK_EN = 27;
    localparam int FIELDBUS_CLK_EN = 25;
    localparam int USB_CLK_EN = 23;
    localparam int TWOWIRE_B_CLK_EN = 22;
    localparam int TWOWIRE_A_CLK_EN = 21;
    localparam int SERIAL_5_CLK_EN = 20;
    localparam int SERIAL_4_CLK_EN = 19;
    localparam int SERIAL_3_CLK_EN = 18;
    localparam int SERIAL_2_CLK_EN = 17;
    localparam int SYNC_SERIAL_C_CLK_EN = 15;
    localparam int SYNC_SERIAL_B_CLK_EN = 14;
    localparam int WINDOW_WATCHDOG_CLK_EN = 11;
    localparam int TIMER_7_CLK_EN = 5;
    localparam int TIMER_2_CLK_EN = 0;

    // Writable gate bits; everything else is reserved and reads zero
    localparam logic [31:0] GATE_MASK = (32'h1 << CONVERTER_OUT_CLK_EN) | (32'h1 << POWER_CTL_CLK_EN)
        | (32'h1 << BACKUP_IF_CLK_EN) | (32'h1 << FIELDBUS_CLK_EN) | (32'h1 << USB_CLK_EN)
        | (32'h1 << TWOWIRE_B_CLK_EN) | (32'h1 << TWOWIRE_A_CLK_EN) | (32'h1 << SERIAL_5_CLK_EN)
        | (32'h1 << SERIAL_4_CLK_EN) | (32'h1 << SERIAL_3_CLK_EN) | (32'h1 << SERIAL_2_CLK_EN)
        | (32'h1 << SYNC_SERIAL_C_CLK_EN) | (32'h1 << SYNC_SERIAL_B_CLK_EN)
        | (32'h1 << WINDOW_WATCHDOG_CLK_EN)
        | (32'h3f << TIMER_2_CLK_EN);

    // Backup domain control field positions
    localparam int BACKUP_DOMAIN_SW_RESET = 16;
    localparam int CALENDAR_CLK_EN = 15;
    localparam int CALENDAR_CLK_SOURCE_LSB = 8;
    localparam int EXT_SLOW_OSC_GAIN_LSB = 3;
    localparam int EXT_SLOW_OSC_BYPASS = 2;
    localparam int EXT_SLOW_OSC_READY = 1;
    localparam int EXT_SLOW_OSC_ON = 0;
    localparam logic [3:0] GAIN_RESET = 4'h3;

    // Calendar clock source codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_EXT_SLOW = 2'h1;
    localparam logic [1:0] SRC_INT_SLOW = 2'h2;
    localparam logic [1:0] SRC_EXT_FAST_DIV = 2'h3;

    // Timing counts
    localparam int FAST_DIV = 128;
    localparam int FAST_DIV_W = 7;
    localparam logic [2:0] READY_DROP_EDGES = 3'h6;
endpackage
`default_nettype wire

// ---- src/pcgbc_edge_sync.sv ----
`default_nettype none
module pcgbc_edge_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic level,
    output logic risePulse
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Two-flop synchroniser, third flop only for the edge compare
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else if (clkEn) begin
            stage1 <= level;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // One system-clock pulse per rising edge of the slow clock
    assign risePulse = stage2 & ~stage3;
endmodule
`default_nettype wire

// ---- src/pcgbc_cal_mux.sv ----
`default_nettype none
module pcgbc_cal_mux (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic domainReset,
    input wire logic calEnable,
    input wire logic [1:0] source,
    input wire logic extSlowTick,
    input wire logic intSlowTick,
    input wire logic extFastTick,
    output logic calTick
);
    logic [pcgbc_pkg::FAST_DIV_W-1:0] divCount;
    logic divTick;
    logic selTick;

    // Fast oscillator prescaler, cleared with the backup domain
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= '0;
        end else if (clkEn) begin
            if (domainReset) begin
                divCount <= '0;
            end else if (extFastTick) begin
                divCount <= divCount + 1'b1;
            end
        end
    end
    assign divTick = extFastTick && (divCount == pcgbc_pkg::FAST_DIV_W'(pcgbc_pkg::FAST_DIV - 1));

    // Source select
    always_comb begin
        unique case (source)
            pcgbc_pkg::SRC_NONE: selTick = 1'b0;
            pcgbc_pkg::SRC_EXT_SLOW: selTick = extSlowTick;
            pcgbc_pkg::SRC_INT_SLOW: selTick = intSlowTick;
            pcgbc_pkg::SRC_EXT_FAST_DIV: selTick = divTick;
        endcase
    end

    // Gated output; a tick stands for one cycle of the delivered clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            calTick <= 1'b0;
        end else if (clkEn) begin
            calTick <= selTick && calEnable && !domainReset;
        end
    end

    a_cal_gated: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && !calEnable) |=> !calTick)
        else $error("calendar tick while disabled");
    a_no_source: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && source == pcgbc_pkg::SRC_NONE) |=> !calTick)
        else $error("calendar tick with no source");
    a_fast_divide: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && calEnable && !domainReset && source == pcgbc_pkg::SRC_EXT_FAST_DIV && divTick) |=> calTick)
        else $error("divided fast tick not delivered");
endmodule
`default_nettype wire

// ---- src/pcgbc_top.sv ----
// The APB interface to the registers was decided locally.
`default_nettype none
module pcgbc_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [pcgbc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extSlowOscClk,
    input wire logic extSlowOscStable,
    input wire logic intSlowOscClk,
    input wire logic extFastOscClk,
    output logic [31:0] periphClkEn,
    output logic backupDomainReset,
    output logic calendarClkTick,
    output logic extSlowOscEnable,
    output logic extSlowOscBypass,
    output logic [3:0] extSlowOscGain
);
    logic calEnable;
    logic [1:0] calSource;
    logic sourceLocked;
    logic oscReady;
    logic [2:0] dropCount;
    logic extSlowTick;
    logic intSlowTick;
    logic extFastTick;
    logic hitGate;
    logic hitBdcr;
    logic accessPhase;
    logic completes;
    logic writeGate;
    logic writeBdcr;
    logic [31:0] bdcrWord;
    logic [31:0] gateMerged;
    logic [31:0] bdcrMerged;
    logic [31:0] readMux;

    // Byte-lane merge so narrow APB writes leave other lanes alone
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord, input logic [31:0] newWord,
                                               input logic [3:0] strb);
        logic [31:0] laneMask;
        laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (oldWord & ~laneMask) | (newWord & laneMask);
    endfunction

    // Oscillator pins are sampled and turned into edge pulses
    pcgbc_edge_sync u_ext_slow_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .level(extSlowOscClk),
        .risePulse(extSlowTick)
    );
    pcgbc_edge_sync u_int_slow_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .level(intSlowOscClk),
        .risePulse(intSlowTick)
    );
    pcgbc_edge_sync u_ext_fast_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .level(extFastOscClk),
        .risePulse(extFastTick)
    );

    // Calendar clock selection and gating
    pcgbc_cal_mux u_cal_mux (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .domainReset(backupDomainReset),
        .calEnable(calEnable),
        .source(calSource),
        .extSlowTick(extSlowTick),
        .intSlowTick(intSlowTick),
        .extFastTick(extFastTick),
        .calTick(calendarClkTick)
    );

    // Address decode; unaligned addresses fall through as unmapped
    assign hitGate = (paddr == pcgbc_pkg::GATE_OFFSET);
    assign hitBdcr = (paddr == pcgbc_pkg::BDCR_OFFSET);
    assign accessPhase = psel && penable && !pready;
    assign completes = psel && penable && pready;
    assign writeGate = completes && pwrite && hitGate;
    assign writeBdcr = completes && pwrite && hitBdcr;

    // Read view of the backup control word, reserved bits zero
    always_comb begin
        bdcrWord = '0;
        bdcrWord[pcgbc_pkg::BACKUP_DOMAIN_SW_RESET] = backupDomainReset;
        bdcrWord[pcgbc_pkg::CALENDAR_CLK_EN] = calEnable;
        bdcrWord[pcgbc_pkg::CALENDAR_CLK_SOURCE_LSB +: 2] = calSource;
        bdcrWord[pcgbc_pkg::EXT_SLOW_OSC_GAIN_LSB +: 4] = extSlowOscGain;
        bdcrWord[pcgbc_pkg::EXT_SLOW_OSC_BYPASS] = extSlowOscBypass;
        bdcrWord[pcgbc_pkg::EXT_SLOW_OSC_READY] = oscReady;
        bdcrWord[pcgbc_pkg::EXT_SLOW_OSC_ON] = extSlowOscEnable;
    end

    assign gateMerged = mergeBytes(periphClkEn, pwdata, pstrb);
    assign bdcrMerged = mergeBytes(bdcrWord, pwdata, pstrb);

    // Read multiplexer
    always_comb begin
        readMux = '0;
        if (hitGate) begin
            readMux = periphClkEn;
        end else if (hitBdcr) begin
            readMux = bdcrWord;
        end
    end

    // APB answer: one wait state, every output registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (clkEn) begin
            pready <= accessPhase;
            pslverr <= accessPhase && !(hitGate || hitBdcr);
            if (accessPhase && !pwrite) begin
                prdata <= readMux;
            end else if (!accessPhase) begin
                prdata <= '0;
            end
        end
    end

    // Peripheral clock gate; the flop drives the gate enables directly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            periphClkEn <= pcgbc_pkg::GATE_RESET;
        end else if (clkEn && writeGate) begin
            periphClkEn <= gateMerged & pcgbc_pkg::GATE_MASK;
        end
    end

    // Backup domain software reset stays writable at all times
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            backupDomainReset <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::BACKUP_DOMAIN_SW_RESET];
        end else if (clkEn && writeBdcr) begin
            backupDomainReset <= bdcrMerged[pcgbc_pkg::BACKUP_DOMAIN_SW_RESET];
        end
    end

    // Plain backup fields; held at reset values while the domain is in reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            calEnable <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::CALENDAR_CLK_EN];
            extSlowOscGain <= pcgbc_pkg::GAIN_RESET;
            extSlowOscEnable <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::EXT_SLOW_OSC_ON];
        end else if (clkEn) begin
            if (backupDomainReset) begin
                calEnable <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::CALENDAR_CLK_EN];
                extSlowOscGain <= pcgbc_pkg::GAIN_RESET;
                extSlowOscEnable <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::EXT_SLOW_OSC_ON];
            end else if (writeBdcr) begin
                calEnable <= bdcrMerged[pcgbc_pkg::CALENDAR_CLK_EN];
                extSlowOscGain <= bdcrMerged[pcgbc_pkg::EXT_SLOW_OSC_GAIN_LSB +: 4];
                extSlowOscEnable <= bdcrMerged[pcgbc_pkg::EXT_SLOW_OSC_ON];
            end
        end
    end

    // Bypass only moves while the oscillator is off, so a running
    // crystal never sees its drive path switched under it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            extSlowOscBypass <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::EXT_SLOW_OSC_BYPASS];
        end else if (clkEn) begin
            if (backupDomainReset) begin
                extSlowOscBypass <= pcgbc_pkg::BDCR_RESET[pcgbc_pkg::EXT_SLOW_OSC_BYPASS];
            end else if (writeBdcr && !extSlowOscEnable) begin
                extSlowOscBypass <= bdcrMerged[pcgbc_pkg::EXT_SLOW_OSC_BYPASS];
            end
        end
    end

    // Source selection locks on the first non-zero choice
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            calSource <= pcgbc_pkg::SRC_NONE;
            sourceLocked <= 1'b0;
        end else if (clkEn) begin
            if (backupDomainReset) begin
                calSource <= pcgbc_pkg::SRC_NONE;
                sourceLocked <= 1'b0;
            end else if (writeBdcr && !sourceLocked) begin
                calSource <= bdcrMerged[pcgbc_pkg::CALENDAR_CLK_SOURCE_LSB +: 2];
                sourceLocked <= (bdcrMerged[pcgbc_pkg::CALENDAR_CLK_SOURCE_LSB +: 2] != pcgbc_pkg::SRC_NONE);
            end
        end
    end

    // Ready follows stability while on; after switch-off it lingers for a
    // fixed number of slow-clock edges, which stall if the crystal stops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oscReady <= 1'b0;
            dropCount <= '0;
        end else if (clkEn) begin
            if (backupDomainReset) begin
                oscReady <= 1'b0;
                dropCount <= '0;
            end else if (extSlowOscEnable) begin
                oscReady <= extSlowOscStable;
                dropCount <= '0;
            end else if (oscReady && extSlowTick) begin
                if (dropCount == pcgbc_pkg::READY_DROP_EDGES - 3'h1) begin
                    oscReady <= 1'b0;
                    dropCount <= '0;
                end else begin
                    dropCount <= dropCount + 3'h1;
                end
            end
        end
    end

    a_gate_write: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && writeGate) |=> periphClkEn == ($past(gateMerged) & pcgbc_pkg::GATE_MASK))
        else $error("gate register did not take write");
    a_gate_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        (periphClkEn & ~pcgbc_pkg::GATE_MASK) == 32'h00000000)
        else $error("reserved gate bit set");
    a_domain_held: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && backupDomainReset) |=> (extSlowOscGain == pcgbc_pkg::GAIN_RESET && !extSlowOscEnable
        && !calEnable && !oscReady))
        else $error("backup fields not held in reset");
    a_domain_unlock: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && backupDomainReset) |=> (!sourceLocked && calSource == pcgbc_pkg::SRC_NONE && !extSlowOscBypass))
        else $error("domain reset did not unlock source");
    a_source_lock: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && sourceLocked && !backupDomainReset) |=> $stable(calSource))
        else $error("locked source changed");
    a_bypass_guard: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && writeBdcr && extSlowOscEnable && !backupDomainReset) |=> $stable(extSlowOscBypass))
        else $error("bypass changed while oscillator on");
    a_ready_follow: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && extSlowOscEnable && !backupDomainReset) |=> (oscReady == $past(extSlowOscStable)))
        else $error("ready not following stability");
    a_ready_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && !backupDomainReset && !extSlowOscEnable && oscReady && extSlowTick && dropCount < 3'h5)
        |=> oscReady)
        else $error("ready dropped too early");
    a_ready_sixth: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && !backupDomainReset && !extSlowOscEnable && oscReady && extSlowTick && dropCount == 3'h5)
        |=> !oscReady)
        else $error("ready not dropped on sixth edge");
    a_apb_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (clkEn && accessPhase && !pwrite && hitBdcr) |=> (pready && prdata == $past(bdcrWord)))
        else $error("control word read wrong");
endmodule
`default_nettype wire

// ---- verif/periph_clock_gate_and_backup_ctrl_test.sv ----
`default_nettype none
module periph_clock_gate_and_backup_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock;
    logic rst_n;
    logic clkEn;
    logic [pcgbc_pkg::ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic extSlowOscClk;
    logic extSlowOscStable;
    logic intSlowOscClk;
    logic extFastOscClk;
    logic [31:0] periphClkEn;
    logic backupDomainReset;
    logic calendarClkTick;
    logic extSlowOscEnable;
    logic extSlowOscBypass;
    logic [3:0] extSlowOscGain;
    int err_total;
    int checked;
    int ticks;
    logic [31:0] rd;
    logic err;
    logic [31:0] val;
    logic [3:0] gain;
    logic [1:0] srcTab [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic enTab [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int expTab [5] = '{0, 256, 256, 2, 0};

    pcgbc_top dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extSlowOscClk(extSlowOscClk),
        .extSlowOscStable(extSlowOscStable), .intSlowOscClk(intSlowOscClk),
        .extFastOscClk(extFastOscClk), .periphClkEn(periphClkEn), .backupDomainReset(backupDomainReset),
        .calendarClkTick(calendarClkTick), .extSlowOscEnable(extSlowOscEnable),
        .extSlowOscBypass(extSlowOscBypass), .extSlowOscGain(extSlowOscGain));

    // System clock, 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Count delivered calendar clock pulses
    always @(posedge clock) begin
        if (calendarClkTick === 1'b1) ticks++;
    end

    // Only the documented enable bits of the gate register are writable
    function automatic logic [31:0] gate_exp(input logic [31:0] wd);
        return wd & 32'h3afec83f;
    endfunction

    // Backup control word as software should read it back
    function automatic logic [31:0] bdcr_exp(input logic en, input logic [1:0] src, input logic [3:0] g,
        input logic [2:0] low);
        return {16'h0, en, 5'h0, src, 1'b0, g, low};
    endfunction

    task automatic final_report();
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            $display("MISMATCH pready expected 1 seen %b", pready);
            err_total++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Rising edges on all three oscillator inputs, each level held two cycles
    task automatic osc_edges(input int n);
        repeat (n) begin
            @(posedge clock);
            extSlowOscClk <= 1'b1;
            intSlowOscClk <= 1'b1;
            extFastOscClk <= 1'b1;
            repeat (2) @(posedge clock);
            extSlowOscClk <= 1'b0;
            intSlowOscClk <= 1'b0;
            extFastOscClk <= 1'b0;
            @(posedge clock);
        end
        repeat (8) @(posedge clock);
    endtask

    // Pulse the software domain reset, leaving the domain released
    task automatic domain_reset();
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h00010000);
        // Register outputs change on the completing edge; sample them one edge later
        @(posedge clock);
        chk("domain reset out", 32'h1, {31'h0, backupDomainReset});
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("bdcr in reset", 32'h00010018, rd);
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h0);
    endtask

    // Watchdog sized well beyond the longest sequence
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        pstrb = 4'hf;
        extSlowOscClk = 1'b0;
        extSlowOscStable = 1'b0;
        intSlowOscClk = 1'b0;
        extFastOscClk = 1'b0;
        err_total = 0;
        checked = 0;
        ticks = 0;
        void'($urandom(32'h47c6));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values seen at the register bus
        apb(1'b0, pcgbc_pkg::GATE_OFFSET, 32'h0);
        chk("gate reset", 32'h0, rd);
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("bdcr reset", 32'h00000018, rd);
        chk("gain out reset", 32'h3, {28'h0, extSlowOscGain});
        // Gate register: corners then random words, reserved bits must stay zero
        for (int i = 0; i < 10; i++) begin
            val = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
            apb(1'b1, pcgbc_pkg::GATE_OFFSET, val);
            apb(1'b0, pcgbc_pkg::GATE_OFFSET, 32'h0);
            chk("gate read", gate_exp(val), rd);
            chk("gate out", gate_exp(val), periphClkEn);
        end
        // Unmapped address is refused and leaves the gate alone
        apb(1'b1, 12'h024, 32'hffffffff);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, pcgbc_pkg::GATE_OFFSET, 32'h0);
        chk("gate after unmapped", gate_exp(val), rd);
        // Every source code, plus enable off; then a relock attempt
        for (int i = 0; i < 5; i++) begin
            domain_reset();
            gain = 4'($urandom);
            apb(1'b1, pcgbc_pkg::BDCR_OFFSET, bdcr_exp(enTab[i], srcTab[i], gain, 3'h0) | 32'hfffe7c80);
            apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
            chk("bdcr fields", bdcr_exp(enTab[i], srcTab[i], gain, 3'h0), rd);
            chk("gain out", {28'h0, gain}, {28'h0, extSlowOscGain});
            ticks = 0;
            osc_edges(256);
            chk("calendar ticks", expTab[i], ticks);
            apb(1'b1, pcgbc_pkg::BDCR_OFFSET, bdcr_exp(enTab[i], ~srcTab[i], gain, 3'h0));
            apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
            val = bdcr_exp(enTab[i], (srcTab[i] == 2'h0) ? 2'h3 : srcTab[i], gain, 3'h0);
            chk("source lock", val, rd);
        end
        // Source unlocked again after the domain reset
        domain_reset();
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, bdcr_exp(1'b0, 2'h2, 4'h3, 3'h0));
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("source unlocked", bdcr_exp(1'b0, 2'h2, 4'h3, 3'h0), rd);
        // Oscillator on, ready follows stability, bypass refused while on
        domain_reset();
        extSlowOscStable <= 1'b1;
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h00000019);
        @(posedge clock);
        chk("osc enable out", 32'h1, {31'h0, extSlowOscEnable});
        repeat (3) @(posedge clock);
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h0000001d);
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("ready and bypass held", 32'h0000001b, rd);
        // Switch off: ready must survive five slow edges and fall after the sixth
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h00000018);
        @(posedge clock);
        chk("osc enable off", 32'h0, {31'h0, extSlowOscEnable});
        osc_edges(5);
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("ready after five", 32'h0000001a, rd);
        osc_edges(1);
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("ready after six", 32'h00000018, rd);
        // Bypass accepted once the oscillator is off
        apb(1'b1, pcgbc_pkg::BDCR_OFFSET, 32'h0000001c);
        apb(1'b0, pcgbc_pkg::BDCR_OFFSET, 32'h0);
        chk("bypass read", 32'h0000001c, rd);
        chk("bypass out", 32'h1, {31'h0, extSlowOscBypass});
        final_report();
    end
endmodule
`default_nettype wire
